// [hdl/lcdhi_top.sv]
// Purpose: host port of a dot-matrix display driver: parallel and serial transfer
// Assumes: all host pins synchronous to clk_sys; core supplies read bytes
// Notes: parallel outputs lag the pins by one cycle, serial bytes lag the serial clock by two
//
// Contract
// - separate-strobe style: drive data bus while read strobe low and selected
// - enable-strobe style: first strobe pin is an active-high enable clock
// - respond to bus signals only while chip select is low
// - separate-strobe style: capture data on leading edge of write strobe
// - enable-strobe style: second strobe pin high reads, low writes
// - command/data line high: byte is display data or command parameter
// - command/data line low: byte is a control command
// - parallel data path is one bidirectional eight-bit bus
// - serial mode: six lowest data pins stay high impedance
// - chip select high: all eight data pins released
// - initialise whenever reset input is low
// - reset acts on its low level, not on an edge
// - strap high selects parallel interface, low selects serial
`timescale 1ns/10ps
`default_nettype none
module lcdhi_top
	import lcdhi_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic cs_n,
	input wire logic host_strobe_a,
	input wire logic host_strobe_b,
	input wire logic cmd_data_select,
	input wire logic host_bus_style_select,
	input wire logic parallel_select,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic [7:0] data_oe,
	input wire logic [7:0] rd_byte,
	output logic rd_req,
	output logic xfer_valid,
	output logic xfer_is_data,
	output logic [7:0] xfer_byte,
	output logic mode_serial,
	output logic style_enable
);
	lcdhi_ser_if ser ();
	lcdhi_mode_e mode;
	logic a_rise;
	logic a_fall;
	logic b_fall;
	logic sck_rise;
	logic wr_take;
	logic rd_active;
	logic rd_start;
	logic ser_take;

	// strap: caught by the first edge after reset release, then frozen
	logic par_q;
	logic par_d;
	logic strap_done_q;
	logic strap_done_d;
	logic style_q;
	logic style_d;

	always_comb begin
		par_d = par_q;
		strap_done_d = 1'b1;
		style_d = host_bus_style_select;
		if (!strap_done_q) begin
			par_d = parallel_select;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			par_q <= PAR_RST;
			strap_done_q <= FLAG_RST;
			style_q <= STYLE_SEP;
		end else begin
			par_q <= par_d;
			strap_done_q <= strap_done_d;
			style_q <= style_d;
		end
	end

	// decode from the capture edge on, so a serial strap never sees a parallel read
	always_comb begin
		if (!par_d) begin
			mode = LCDHI_SERIAL;
		end else if (host_bus_style_select == STYLE_ENA) begin
			mode = LCDHI_ENA_STROBE;
		end else begin
			mode = LCDHI_SEP_STROBE;
		end
	end

	lcdhi_edge #(.IDLE(PIN_IDLE_HI)) u_edge_a (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.level(host_strobe_a),
		.rise(a_rise),
		.fall(a_fall)
	);

	lcdhi_edge #(.IDLE(PIN_IDLE_HI)) u_edge_b (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.level(host_strobe_b),
		.rise(),
		.fall(b_fall)
	);

	lcdhi_edge #(.IDLE(PIN_IDLE_HI)) u_edge_sck (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.level(data_in[SER_CLK_PIN]),
		.rise(sck_rise),
		.fall()
	);

	// strobe decode; nothing is taken while deselected
	always_comb begin
		wr_take = 1'b0;
		rd_active = 1'b0;
		rd_start = 1'b0;
		case (mode)
			LCDHI_SEP_STROBE: begin
				// both strobes low at once is illegal and is ignored
				wr_take = b_fall && host_strobe_a;
				rd_active = !host_strobe_a && host_strobe_b;
				rd_start = a_fall && host_strobe_b;
			end
			LCDHI_ENA_STROBE: begin
				// writes latch as the enable clock falls
				wr_take = a_fall && !host_strobe_b;
				rd_active = host_strobe_a && host_strobe_b;
				rd_start = a_rise && host_strobe_b;
			end
			default: begin
				wr_take = 1'b0;
				rd_active = 1'b0;
				rd_start = 1'b0;
			end
		endcase
		if (cs_n) begin
			wr_take = 1'b0;
			rd_active = 1'b0;
			rd_start = 1'b0;
		end
	end

	// serial path: pins fixed by mode, shifting only while selected
	assign ser.shift_en = (mode == LCDHI_SERIAL) && !cs_n;
	assign ser.sample = sck_rise;
	assign ser.bit_in = data_in[SER_DATA_PIN];
	assign ser_take = ser.done && (mode == LCDHI_SERIAL) && !cs_n;

	lcdhi_shift u_shift (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.ser(ser)
	);

	// the select level is held from the last serial bit, relying on the host
	// keeping it steady across the byte
	logic cds_ser_q;
	logic cds_ser_d;
	logic [7:0] data_out_q;
	logic [7:0] data_out_d;
	logic [7:0] oe_q;
	logic [7:0] oe_d;
	logic rd_req_q;
	logic rd_req_d;
	logic xv_q;
	logic xv_d;
	logic xd_q;
	logic xd_d;
	logic [7:0] xb_q;
	logic [7:0] xb_d;

	always_comb begin
		cds_ser_d = cds_ser_q;
		if (ser.shift_en && ser.sample) begin
			cds_ser_d = cmd_data_select;
		end
		oe_d = rd_active ? OE_ALL : OE_NONE;
		data_out_d = rd_active ? rd_byte : data_out_q;
		rd_req_d = rd_start;
		xv_d = wr_take || ser_take;
		xd_d = xd_q;
		xb_d = xb_q;
		if (wr_take) begin
			xd_d = cmd_data_select;
			xb_d = data_in;
		end else if (ser_take) begin
			xd_d = cds_ser_q;
			xb_d = ser.byte_val;
		end
	end

	// every output stays at its reset value for as long as reset is low
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cds_ser_q <= FLAG_RST;
			data_out_q <= BYTE_RST;
			oe_q <= OE_NONE;
			rd_req_q <= FLAG_RST;
			xv_q <= FLAG_RST;
			xd_q <= FLAG_RST;
			xb_q <= BYTE_RST;
		end else begin
			cds_ser_q <= cds_ser_d;
			data_out_q <= data_out_d;
			oe_q <= oe_d;
			rd_req_q <= rd_req_d;
			xv_q <= xv_d;
			xd_q <= xd_d;
			xb_q <= xb_d;
		end
	end

	assign data_out = data_out_q;
	assign data_oe = oe_q;
	assign rd_req = rd_req_q;
	assign xfer_valid = xv_q;
	assign xfer_is_data = xd_q;
	assign xfer_byte = xb_q;
	assign mode_serial = ~par_q;
	assign style_enable = style_q;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	property p_sep_read_drive;
		(mode == LCDHI_SEP_STROBE && !cs_n && !host_strobe_a && host_strobe_b)
		|=> data_oe == 8'hff;
	endproperty
	a_sep_read_drive: assert property (p_sep_read_drive) else $error("bus not driven on read");

	property p_ena_read_drive;
		(mode == LCDHI_ENA_STROBE && !cs_n && host_strobe_a && host_strobe_b)
		|=> data_oe == 8'hff;
	endproperty
	a_ena_read_drive: assert property (p_ena_read_drive) else $error("enable read not driven");

	property p_deselect_quiet;
		cs_n |=> (!xfer_valid && !rd_req);
	endproperty
	a_deselect_quiet: assert property (p_deselect_quiet) else $error("transfer while deselected");

	property p_sep_write;
		(mode == LCDHI_SEP_STROBE && !cs_n && b_fall && host_strobe_a)
		|=> (xfer_valid && xfer_byte == $past(data_in));
	endproperty
	a_sep_write: assert property (p_sep_write) else $error("write strobe byte lost");

	property p_ena_dir;
		(mode == LCDHI_ENA_STROBE && !cs_n && a_fall)
		|=> (xfer_valid == !$past(host_strobe_b));
	endproperty
	a_ena_dir: assert property (p_ena_dir) else $error("direction line misread");

	property p_data_class;
		(wr_take && cmd_data_select) |=> xfer_is_data;
	endproperty
	a_data_class: assert property (p_data_class) else $error("data byte classed as command");

	property p_cmd_class;
		(wr_take && !cmd_data_select) |=> (xfer_valid && !xfer_is_data);
	endproperty
	a_cmd_class: assert property (p_cmd_class) else $error("command byte classed as data");

	property p_oe_whole;
		data_oe == 8'h00 || data_oe == 8'hff;
	endproperty
	a_oe_whole: assert property (p_oe_whole) else $error("data bus partly driven");

	property p_serial_hiz;
		(mode == LCDHI_SERIAL) |=> data_oe[5:0] == 6'h00;
	endproperty
	a_serial_hiz: assert property (p_serial_hiz) else $error("low pins driven in serial mode");

	property p_cs_release;
		cs_n |=> data_oe == 8'h00;
	endproperty
	a_cs_release: assert property (p_cs_release) else $error("bus driven while deselected");

	property p_reset_quiet;
		disable iff (1'b0)
		!reset_n |-> (data_oe == 8'h00 && !xfer_valid && !rd_req);
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");

	property p_reset_level;
		disable iff (1'b0)
		(!reset_n ##1 !reset_n) |-> (xfer_byte == 8'h00 && data_out == 8'h00);
	endproperty
	a_reset_level: assert property (p_reset_level) else $error("state kept under held reset");

	property p_par_no_serial;
		par_q |=> !(xfer_valid && !$past(wr_take));
	endproperty
	a_par_no_serial: assert property (p_par_no_serial) else $error("serial byte in parallel mode");

	c_sep_write: cover property (mode == LCDHI_SEP_STROBE ##1 xfer_valid);
	c_ena_read: cover property (mode == LCDHI_ENA_STROBE && rd_start ##1 data_oe == 8'hff);
	c_ser_byte: cover property (ser_take ##1 xfer_valid);
	c_cs_drop_read: cover property (rd_active ##1 cs_n);
endmodule
`default_nettype wire

// [hdl/lcdhi_pkg.sv]
// Purpose: shared constants and types of the display driver host port
// Assumes: all pins are synchronous to clk_sys
// Notes: one byte-wide bus, two strobe styles and a write-only serial mode
package lcdhi_pkg;
	localparam int unsigned BUS_W = 8;
	localparam int unsigned BIT_CNT_W = 3;
	localparam int unsigned SER_DATA_PIN = 7;
	localparam int unsigned SER_CLK_PIN = 6;
	localparam logic [2:0] BIT_CNT_RST = 3'h0;
	localparam logic [2:0] BIT_CNT_LAST = 3'h7;
	localparam logic [7:0] OE_ALL = 8'hff;
	localparam logic [7:0] OE_NONE = 8'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic STYLE_SEP = 1'b0;
	localparam logic STYLE_ENA = 1'b1;
	localparam logic PAR_RST = 1'b1;
	localparam logic PIN_IDLE_HI = 1'b1;
	localparam logic FLAG_RST = 1'b0;

	typedef enum logic [1:0] {
		LCDHI_SERIAL,
		LCDHI_SEP_STROBE,
		LCDHI_ENA_STROBE
	} lcdhi_mode_e;
endpackage

// [hdl/lcdhi_ser_if.sv]
// Purpose: carries serial bit samples and finished bytes between core and shifter
// Assumes: one clock domain, clk_sys
// Notes: done is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
interface lcdhi_ser_if;
	logic shift_en;
	logic sample;
	logic bit_in;
	logic done;
	logic [7:0] byte_val;

	modport core (output shift_en, output sample, output bit_in, input done, input byte_val);
	modport shifter (input shift_en, input sample, input bit_in, output done, output byte_val);
endinterface
`default_nettype wire

// [hdl/lcdhi_edge.sv]
// Purpose: edge detector for one host pin
// Assumes: pin already synchronous to clk_sys
// Notes: no edge is reported at the first sample after reset, whatever the pin level
`timescale 1ns/10ps
`default_nettype none
module lcdhi_edge
	import lcdhi_pkg::*;
#(
	parameter logic IDLE = PIN_IDLE_HI
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic level,
	output logic rise,
	output logic fall
);
	logic prev_q;
	logic prev_d;
	// a pin held active through reset release must not look like a fresh strobe
	logic armed_q;
	logic armed_d;

	always_comb begin
		prev_d = level;
		armed_d = 1'b1;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			prev_q <= IDLE;
			armed_q <= FLAG_RST;
		end else begin
			prev_q <= prev_d;
			armed_q <= armed_d;
		end
	end

	assign rise = armed_q & level & ~prev_q;
	assign fall = armed_q & ~level & prev_q;
endmodule
`default_nettype wire

// [hdl/lcdhi_shift.sv]
// Purpose: msb-first serial shifter for the write-only serial mode
// Assumes: sample pulses once per rising serial clock
// Notes: bit count restarts whenever shifting is disabled
`timescale 1ns/10ps
`default_nettype none
module lcdhi_shift
	import lcdhi_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	lcdhi_ser_if.shifter ser
);
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic [7:0] sh_q;
	logic [7:0] sh_d;
	logic done_q;
	logic done_d;
	logic [7:0] byte_q;
	logic [7:0] byte_d;

	always_comb begin
		cnt_d = cnt_q;
		sh_d = sh_q;
		done_d = 1'b0;
		byte_d = byte_q;
		if (!ser.shift_en) begin
			// a half byte left by a dropped select is discarded
			cnt_d = BIT_CNT_RST;
		end else if (ser.sample) begin
			sh_d = {sh_q[6:0], ser.bit_in};
			cnt_d = cnt_q + 3'h1;
			if (cnt_q == BIT_CNT_LAST) begin
				done_d = 1'b1;
				byte_d = {sh_q[6:0], ser.bit_in};
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= BIT_CNT_RST;
			sh_q <= BYTE_RST;
			done_q <= FLAG_RST;
			byte_q <= BYTE_RST;
		end else begin
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			done_q <= done_d;
			byte_q <= byte_d;
		end
	end

	assign ser.done = done_q;
	assign ser.byte_val = byte_q;

	property p_ser_byte;
		@(posedge clk_sys) disable iff (!reset_n)
		(ser.shift_en && ser.sample && cnt_q == 3'h7)
		|=> (ser.done && ser.byte_val == {$past(sh_q[6:0]), $past(ser.bit_in)});
	endproperty
	a_ser_byte: assert property (p_ser_byte) else $error("serial byte not assembled msb first");
endmodule
`default_nettype wire

// [test/lcdhi_host_model.sv]
// Purpose: host microprocessor model driving the display driver host pins
// Assumes: pins change only at falling clk_sys edges, one task at a time
// Notes: released data lines show the inverse of the last value, never a stale copy
`timescale 1ns/10ps
`default_nettype none
module lcdhi_host_model (
	input wire logic clk_sys,
	output logic cs_n,
	output logic strobe_a,
	output logic strobe_b,
	output logic cmd_data_select,
	output logic style,
	output logic [7:0] host_d
);
	initial begin
		cs_n = 1'b1;
		strobe_a = 1'b1;
		strobe_b = 1'b1;
		cmd_data_select = 1'b0;
		style = 1'b0;
		host_d = 8'h00;
	end

	// one deselected cycle sets the new style and the idle strobe levels together, so their edges are not taken
	task automatic idle(input logic sty);
		@(negedge clk_sys);
		cs_n = 1'b1;
		style = sty;
		strobe_a = !sty;
		strobe_b = 1'b1;
	endtask

	task automatic write(input logic sty, input logic cd, input logic [7:0] b, input logic sel_n);
		idle(sty);
		@(negedge clk_sys);
		cs_n = sel_n;
		cmd_data_select = cd;
		host_d = b;
		if (sty) begin
			strobe_b = 1'b0;
		end
		@(negedge clk_sys);
		if (sty) strobe_a = 1'b1;
		else strobe_b = 1'b0;
		repeat (2) @(negedge clk_sys);
		if (sty) strobe_a = 1'b0;
		else strobe_b = 1'b1;
		repeat (3) @(negedge clk_sys);
		idle(sty);
		host_d = ~b;
	endtask

	task automatic read_on(input logic sty, input logic sel_n);
		idle(sty);
		@(negedge clk_sys);
		cs_n = sel_n;
		strobe_b = 1'b1;
		strobe_a = sty;
	endtask

	task automatic read_off(input logic sty);
		idle(sty);
	endtask

	// msb first, data set while the serial clock is low, rising edge samples
	task automatic ser(input logic cd, input logic [7:0] b, input int nbits);
		@(negedge clk_sys);
		host_d[6] = 1'b0;
		@(negedge clk_sys);
		cs_n = 1'b0;
		cmd_data_select = cd;
		for (int i = 7; i > 7 - nbits; i--) begin
			@(negedge clk_sys);
			host_d[7] = b[i];
			host_d[6] = 1'b0;
			@(negedge clk_sys);
			host_d[6] = 1'b1;
		end
		@(negedge clk_sys);
		host_d[6] = 1'b0;
		repeat (3) @(negedge clk_sys);
		cs_n = 1'b1;
		host_d[7] = ~host_d[7];
	endtask
endmodule
`default_nettype wire

// [test/lcdhi_bench.sv]
// Purpose: self-checking bench of the display driver host port
// Assumes: host model drives all pins at falling edges
// Notes: write/read counts come from a monitor sampling at rising edges
`timescale 1ns/10ps
`default_nettype none
module lcdhi_bench;
	import lcdhi_pkg::*;
	logic clk_sys, reset_n, parallel_select, cs_n, sa, sb, cds, sty;
	logic [7:0] host_d, data_in, data_out, data_oe, rd_byte, xfer_byte, b;
	logic rd_req, xfer_valid, xfer_is_data, mode_serial, style_enable, cs_q, cd;
	int err_count, samples_checked, n_xfer, n_rd, n;

	assign data_in = (|data_oe) ? data_out : host_d;

	lcdhi_host_model lcdhi_host_model_i (.clk_sys(clk_sys), .cs_n(cs_n), .strobe_a(sa),
		.strobe_b(sb), .cmd_data_select(cds), .style(sty), .host_d(host_d));

	lcdhi_top lcdhi_top_i (.clk_sys(clk_sys), .reset_n(reset_n), .cs_n(cs_n),
		.host_strobe_a(sa), .host_strobe_b(sb), .cmd_data_select(cds),
		.host_bus_style_select(sty), .parallel_select(parallel_select), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe), .rd_byte(rd_byte), .rd_req(rd_req),
		.xfer_valid(xfer_valid), .xfer_is_data(xfer_is_data), .xfer_byte(xfer_byte),
		.mode_serial(mode_serial), .style_enable(style_enable));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	function automatic logic [7:0] exp_oe(input logic par, input logic sel_n);
		return (par && !sel_n) ? OE_ALL : OE_NONE;
	endfunction

	task automatic chk(input logic ok, input string m);
		samples_checked++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		if (xfer_valid === 1'b1) n_xfer++;
		if (rd_req === 1'b1) n_rd++;
		if (reset_n && mode_serial === 1'b1) chk(data_oe === OE_NONE, "serial drive");
		if (reset_n && cs_q) chk(data_oe === OE_NONE, "drive deselected");
		cs_q = cs_n;
	end

	task automatic zero_chk;
		chk({data_oe, data_out, xfer_byte} === 24'h000000, "reset bus");
		chk({rd_req, xfer_valid, xfer_is_data, mode_serial, style_enable} === 5'h00, "reset flags");
	endtask

	task automatic do_reset(input logic strap);
		@(negedge clk_sys);
		reset_n = 1'b0;
		parallel_select = strap;
		#1 zero_chk();
		repeat (16) @(negedge clk_sys);
		zero_chk();
		reset_n = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk(mode_serial === !strap, "strap");
	endtask

	task automatic par_write(input logic s, input logic c, input logic [7:0] v, input logic sel_n);
		n = n_xfer;
		lcdhi_host_model_i.write(s, c, v, sel_n);
		chk(n_xfer == n + (sel_n ? 0 : 1), "write count");
		if (!sel_n) chk(xfer_byte === v, "write byte");
		if (!sel_n) chk(xfer_is_data === c, "write kind");
		chk(style_enable === s, "style echo");
	endtask

	initial begin
		void'($urandom(20349));
		reset_n = 1'b0;
		parallel_select = 1'b1;
		rd_byte = 8'h00;
		do_reset(1'b1);
		for (int i = 0; i < 20; i++) begin
			b = (i < 4) ? {8{i[1]}} : 8'($urandom);
			par_write(i[0], i[1], b, 1'b0);
		end
		par_write(1'b0, 1'b1, 8'h5a, 1'b1);
		par_write(1'b1, 1'b0, 8'ha5, 1'b1);
		for (int i = 0; i < 12; i++) begin
			cd = (i > 3) && ($urandom % 4 == 0);
			rd_byte = 8'($urandom);
			n = n_rd;
			lcdhi_host_model_i.read_on(i[0], cd);
			repeat (2) @(negedge clk_sys);
			chk(data_oe === exp_oe(1'b1, cd), "read enable");
			if (!cd) chk(data_out === rd_byte, "read data");
			chk(n_rd == n + (cd ? 0 : 1), "read request");
			lcdhi_host_model_i.read_off(i[0]);
			repeat (2) @(negedge clk_sys);
			chk(data_oe === OE_NONE, "read release");
		end
		lcdhi_host_model_i.read_on(1'b0, 1'b0);
		repeat (3) @(negedge clk_sys);
		do_reset(1'b0);
		lcdhi_host_model_i.read_off(1'b0);
		for (int i = 0; i < 10; i++) begin
			b = (i == 0) ? 8'h80 : 8'($urandom);
			cd = i[0];
			n = n_xfer;
			if (i == 3) lcdhi_host_model_i.ser(~cd, ~b, 3);
			lcdhi_host_model_i.ser(cd, b, 8);
			chk(n_xfer == n + 1, "serial count");
			chk(xfer_byte === b, "serial byte");
			chk(xfer_is_data === cd, "serial kind");
		end
		print_verdict();
	end

	initial begin
		#200000;
		err_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
